// ### rtl/msl_pkg.sv
/*
 * constants, field layouts and carrier types shared by the serial latch block.
 * assumes an apb master on pclk and serial pins that are asynchronous to pclk.
 */
// Overview of operation
// - select input steers serial pins between two paths
// - shift clock rise advances only selected register
// - select low: strobe rise loads on/off bits
// - select high: trim latches follow while strobe high
// - strobe low holds trim contents unchanged
// - open lamp or overheat pulls error low
// - trim path 16 words of 7, msb first
// - on/off path 16 bits, msb first
package msl_pkg;

    // serial geometry defaults
    localparam int MSL_CHANNELS = 16;
    localparam int MSL_TRIM_BITS = 7;

    // apb address width and register byte offsets
    localparam int MSL_ADDR_W = 12;
    localparam logic [11:0] MSL_OFS_ONOFF = 12'h000;
    localparam logic [11:0] MSL_OFS_STATUS = 12'h004;
    localparam logic [11:0] MSL_OFS_MASK = 12'h008;
    localparam logic [11:0] MSL_OFS_PINS = 12'h00C;
    localparam logic [11:0] MSL_OFS_TRIM_BASE = 12'h040;
    localparam logic [11:0] MSL_OFS_TRIM_END = 12'h07C;

    // word index shift for the trim array
    localparam int MSL_WORD_SHIFT = 2;

    // status and mask bit positions
    localparam int MSL_EV_ONOFF = 0;
    localparam int MSL_EV_TRIM = 1;
    localparam int MSL_EV_ERROR = 2;
    localparam int MSL_EV_W = 3;

    // pin status bit positions
    localparam int MSL_PIN_SEL = 0;
    localparam int MSL_PIN_STROBE = 1;
    localparam int MSL_PIN_ERR = 2;

    // reset values
    localparam logic [2:0] MSL_MASK_RST = 3'h0;
    localparam logic [31:0] MSL_RDATA_RST = 32'h0000_0000;

    // serial pins that travel together through the synchroniser
    typedef struct packed {
        logic shift_clock;
        logic serial_data_input;
        logic latch_strobe;
        logic register_select;
    } msl_pins_t;

    // detector inputs, also synchronised
    typedef struct packed {
        logic [15:0] open_lamp_detect;
        logic overheat_flag;
    } msl_detect_t;

    localparam msl_pins_t MSL_PINS_RST = '{1'b0, 1'b0, 1'b0, 1'b0};
    localparam msl_detect_t MSL_DETECT_RST = '{16'h0000, 1'b0};

endpackage

// ### rtl/msl_serial_latch.sv
/*
 * serial load and latch logic of a sixteen channel sink driver, sampled on
 * pclk, with an apb register view, sticky events and an interrupt.
 * assumes the serial shift clock is far slower than pclk (several pclk
 * periods per phase) and that all pin inputs are asynchronous to pclk.
 */
`timescale 1ns/1ps
module msl_serial_latch
    import msl_pkg::*;
#(
    parameter int CHANNELS = MSL_CHANNELS,
    parameter int TRIM_BITS = MSL_TRIM_BITS
)
(
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [MSL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic shift_clock,
    input wire logic serial_data_input,
    input wire logic latch_strobe,
    input wire logic register_select,
    output logic chain_data_output,
    // detector inputs
    input wire logic [CHANNELS-1:0] open_lamp_detect,
    input wire logic overheat_flag,
    // open-drain error pin: level always low, enable high while pulling
    output logic error_flag_n_out,
    output logic error_flag_n_oe,
    // channel state towards the current sinks
    output logic [CHANNELS-1:0] channel_on,
    output logic [CHANNELS*TRIM_BITS-1:0] brightness_trim,
    // level interrupt
    output logic irq
);

    localparam int TRIM_LEN = CHANNELS * TRIM_BITS;

    // refuse geometries the register map cannot hold
    generate
        if (CHANNELS != MSL_CHANNELS || TRIM_BITS < 1 || TRIM_BITS > 32)
        begin : g_bad_geometry
            $error("msl_serial_latch: unsupported channel or trim width");
        end
    endgenerate

    // two-flop synchroniser stages; first stage is read only by the second
    msl_pins_t pins_meta_reg;
    msl_pins_t pins_sync_reg;
    msl_pins_t pins_prev_reg;
    msl_detect_t det_meta_reg;
    msl_detect_t det_sync_reg;

    // shift paths and held registers
    logic [CHANNELS-1:0] onoff_shift_reg;
    logic [TRIM_LEN-1:0] trim_shift_reg;
    logic [CHANNELS-1:0] onoff_reg;
    logic [TRIM_LEN-1:0] trim_reg;

    // error pin and event state
    logic error_reg;
    logic [MSL_EV_W-1:0] status_reg;
    logic [MSL_EV_W-1:0] mask_reg;
    logic [MSL_EV_W-1:0] event_pulse;
    logic irq_reg;
    logic chain_reg;

    // apb answer state
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ready_reg;
    logic err_reg;
    logic addr_ok;

    // edges seen on the synchronised pins
    logic clk_rise;
    logic strobe_rise;
    logic strobe_fall;
    logic error_now;

    // synchronise serial and detector pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins_meta_reg <= MSL_PINS_RST;
            pins_sync_reg <= MSL_PINS_RST;
            pins_prev_reg <= MSL_PINS_RST;
            det_meta_reg <= MSL_DETECT_RST;
            det_sync_reg <= MSL_DETECT_RST;
        end
        else
        begin
            pins_meta_reg <= '{shift_clock, serial_data_input, latch_strobe,
                               register_select};
            pins_sync_reg <= pins_meta_reg;
            pins_prev_reg <= pins_sync_reg;
            det_meta_reg <= '{open_lamp_detect, overheat_flag};
            det_sync_reg <= det_meta_reg;
        end
    end

    // edge detection on the second stage only
    assign clk_rise = pins_sync_reg.shift_clock & ~pins_prev_reg.shift_clock;
    assign strobe_rise = pins_sync_reg.latch_strobe & ~pins_prev_reg.latch_strobe;
    assign strobe_fall = ~pins_sync_reg.latch_strobe & pins_prev_reg.latch_strobe;

    // a detected open lamp or overheat condition
    assign error_now = (|det_sync_reg.open_lamp_detect) | det_sync_reg.overheat_flag;

    // on/off shift path: moves only while select is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            onoff_shift_reg <= '0;
        end
        else if (clk_rise && !pins_sync_reg.register_select)
        begin
            // msb first: new bit enters at bit 0, oldest leaves at the top
            onoff_shift_reg <= {onoff_shift_reg[CHANNELS-2:0],
                                pins_sync_reg.serial_data_input};
        end
    end

    // trim shift path: moves only while select is high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trim_shift_reg <= '0;
        end
        else if (clk_rise && pins_sync_reg.register_select)
        begin
            // channel 15 word goes first and ends in the top bits
            trim_shift_reg <= {trim_shift_reg[TRIM_LEN-2:0],
                               pins_sync_reg.serial_data_input};
        end
    end

    // on/off register: edge-triggered by the strobe rise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            onoff_reg <= '0;
        end
        else if (strobe_rise && !pins_sync_reg.register_select)
        begin
            onoff_reg <= onoff_shift_reg;
        end
    end

    // trim registers: transparent while strobe high, held while low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trim_reg <= '0;
        end
        else if (pins_sync_reg.latch_strobe && pins_sync_reg.register_select)
        begin
            // the controller keeps clock and data still meanwhile
            trim_reg <= trim_shift_reg;
        end
        // otherwise trim_reg keeps its value
    end

    // serial output follows the tail of the selected path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chain_reg <= 1'b0;
        end
        else
        begin
            chain_reg <= pins_sync_reg.register_select ? trim_shift_reg[TRIM_LEN-1]
                                                       : onoff_shift_reg[CHANNELS-1];
        end
    end

    // error pin pull-down enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            error_reg <= 1'b0;
        end
        else
        begin
            error_reg <= error_now;
        end
    end

    // one-cycle events feeding the sticky status
    always_comb
    begin
        event_pulse = '0;
        event_pulse[MSL_EV_ONOFF] = strobe_rise & ~pins_sync_reg.register_select;
        // trim load completes when the strobe returns low
        event_pulse[MSL_EV_TRIM] = strobe_fall & pins_sync_reg.register_select;
        event_pulse[MSL_EV_ERROR] = error_now & ~error_reg;
    end

    // address decode for a mapped word
    assign addr_ok = (paddr == MSL_OFS_ONOFF) || (paddr == MSL_OFS_STATUS) ||
                     (paddr == MSL_OFS_MASK) || (paddr == MSL_OFS_PINS) ||
                     (paddr >= MSL_OFS_TRIM_BASE && paddr <= MSL_OFS_TRIM_END &&
                      paddr[1:0] == 2'b00);

    // sticky status: hardware set wins over software write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg <= '0;
        end
        else if (psel && penable && ready_reg && pwrite && paddr == MSL_OFS_STATUS)
        begin
            status_reg <= (status_reg & ~pwdata[MSL_EV_W-1:0]) | event_pulse;
        end
        else
        begin
            status_reg <= status_reg | event_pulse;
        end
    end

    // interrupt mask register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_reg <= MSL_MASK_RST;
        end
        else if (psel && penable && ready_reg && pwrite && paddr == MSL_OFS_MASK)
        begin
            mask_reg <= pwdata[MSL_EV_W-1:0];
        end
    end

    // level interrupt from unmasked sticky bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |((status_reg | event_pulse) & mask_reg);
        end
    end

    // read mux, evaluated in the setup cycle
    always_comb
    begin
        rdata_next = MSL_RDATA_RST;
        if (paddr == MSL_OFS_ONOFF)
        begin
            rdata_next[CHANNELS-1:0] = onoff_reg;
        end
        else if (paddr == MSL_OFS_STATUS)
        begin
            rdata_next[MSL_EV_W-1:0] = status_reg;
        end
        else if (paddr == MSL_OFS_MASK)
        begin
            rdata_next[MSL_EV_W-1:0] = mask_reg;
        end
        else if (paddr == MSL_OFS_PINS)
        begin
            rdata_next[MSL_PIN_SEL] = pins_sync_reg.register_select;
            rdata_next[MSL_PIN_STROBE] = pins_sync_reg.latch_strobe;
            rdata_next[MSL_PIN_ERR] = error_reg;
        end
        else if (addr_ok)
        begin
            // one trim word per channel, low bits
            rdata_next[TRIM_BITS-1:0] = trim_reg[TRIM_BITS *
                5'((paddr - MSL_OFS_TRIM_BASE) >> MSL_WORD_SHIFT) +: TRIM_BITS];
        end
    end

    // apb answer: ready one cycle after setup, data and error with it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= MSL_RDATA_RST;
        end
        else if (psel && !penable)
        begin
            // setup cycle: prepare the answer
            ready_reg <= 1'b1;
            err_reg <= ~addr_ok;
            rdata_reg <= pwrite ? MSL_RDATA_RST : rdata_next;
        end
        else
        begin
            // access done or idle: drop the answer
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
        end
    end

    // outputs straight from flip-flops, except the error pin level, which is tied low
    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign chain_data_output = chain_reg;
    assign error_flag_n_out = 1'b0;
    assign error_flag_n_oe = error_reg;
    assign channel_on = onoff_reg;
    assign brightness_trim = trim_reg;
    assign irq = irq_reg;

endmodule

// ### verification/msl_ctrl_model.sv
/* behavioural serial controller loading the block's two paths.
   assumes an 800 ns shift clock, unrelated in phase to pclk. */
`timescale 1ns/1ps
module msl_ctrl_model
(
    output logic shift_clock,
    output logic serial_data_input,
    output logic latch_strobe,
    output logic register_select
);
    // pins idle low, clock stands still between frames
    initial
    begin
        {shift_clock, serial_data_input, latch_strobe, register_select} = 4'h0;
    end
    // shifts n bits of v msb first, then pulses the strobe if asked
    task automatic send(input logic sel, input logic [111:0] v, input int n, input logic pulse);
        register_select = sel; // steady for the whole load
        #437;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data_input = v[i]; // msb first
            #400 shift_clock = 1'b1;
            #400 shift_clock = 1'b0;
        end
        if (pulse)
        begin
            #400 latch_strobe = 1'b1; // clock and data still meanwhile
            #800 latch_strobe = 1'b0;
        end
        #400 serial_data_input = ~serial_data_input; // released data
    endtask
endmodule

// ### verification/msl_serial_latch_props.sv
/* port checker for the serial latch block, bound below.
   assumes one pclk domain reset by presetn. */
`timescale 1ns/1ps
module msl_serial_latch_props
#(
    parameter int CHANNELS = 16,
    parameter int TRIM_BITS = 7
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic shift_clock,
    input wire logic latch_strobe,
    input wire logic register_select,
    input wire logic chain_data_output,
    input wire logic [CHANNELS-1:0] open_lamp_detect,
    input wire logic overheat_flag,
    input wire logic error_flag_n_out,
    input wire logic error_flag_n_oe,
    input wire logic [CHANNELS-1:0] channel_on,
    input wire logic [CHANNELS*TRIM_BITS-1:0] brightness_trim
);
    logic [3:0] lat_age, trim_age, sclk_age; // cycles since each cause
    logic sel_d; // select one cycle back
    logic fault; // any detector active
    assign fault = (|open_lamp_detect) || overheat_flag;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // saturating age step
    function automatic logic [3:0] step(input logic [3:0] a, input logic hit);
        return hit ? 4'h0 : (a == 4'hF ? a : a + 4'h1);
    endfunction
    // ages of strobe, clock and select activity
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {lat_age, trim_age, sclk_age, sel_d} <= 13'h1FFE;
        else
        begin
            lat_age <= step(lat_age, latch_strobe && !register_select);
            trim_age <= step(trim_age, latch_strobe && register_select);
            sclk_age <= step(sclk_age, shift_clock || register_select != sel_d);
            sel_d <= register_select;
        end
    onoff_hold_a:
        assert property (!$stable(channel_on) |-> lat_age < 4'h8)
        else $error("on/off moved without strobe");
    trim_hold_a:
        assert property (!$stable(brightness_trim) |-> trim_age < 4'h8)
        else $error("trim moved with strobe low");
    chain_move_a:
        assert property (!$stable(chain_data_output) |-> sclk_age < 4'h8)
        else $error("chain output moved unprompted");
    err_set_a:
        assert property (fault [*7] |-> error_flag_n_oe)
        else $error("error pin not pulled");
    err_clear_a:
        assert property ((!fault) [*7] |-> !error_flag_n_oe)
        else $error("error pin pulled without fault");
    err_level_a:
        assert property (error_flag_n_oe |-> !error_flag_n_out)
        else $error("error pin driven high");
    ready_next_a:
        assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    ready_once_a:
        assert property (pready |=> !pready)
        else $error("ready held too long");
    // main scenarios
    cover property (!$stable(channel_on));
    cover property (!$stable(brightness_trim));
    cover property ($rose(error_flag_n_oe));
endmodule

bind msl_serial_latch msl_serial_latch_props #(
    .CHANNELS(CHANNELS),
    .TRIM_BITS(TRIM_BITS)
) chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .shift_clock(shift_clock),
    .latch_strobe(latch_strobe),
    .register_select(register_select),
    .chain_data_output(chain_data_output),
    .open_lamp_detect(open_lamp_detect),
    .overheat_flag(overheat_flag),
    .error_flag_n_out(error_flag_n_out),
    .error_flag_n_oe(error_flag_n_oe),
    .channel_on(channel_on),
    .brightness_trim(brightness_trim)
);

// ### verification/msl_serial_latch_tb.sv
/* self-checking bench: apb master, serial controller model, detectors.
   assumes the checker binds itself to the block. */
`timescale 1ns/1ps
module msl_serial_latch_tb
    import msl_pkg::*;
;
    logic pclk = 1'b0; // 100 ns clock
    logic presetn = 1'b0; // low for ten cycles
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rerr, chain_data_output, error_flag_n_out, error_flag_n_oe, irq;
    logic shift_clock, serial_data_input, latch_strobe, register_select;
    logic [15:0] open_lamp_detect = 16'h0, channel_on, onoff_v;
    logic overheat_flag = 1'b0;
    logic [111:0] brightness_trim, trim_v, trim_w;
    wire error_n = error_flag_n_oe ? error_flag_n_out : 1'b1; // pull-up
    int mismatches = 0;
    int n_checks = 0;
    logic [31:0] rng = 32'h347EEEA1; // xorshift state
    msl_serial_latch uut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .shift_clock(shift_clock),
        .serial_data_input(serial_data_input),
        .latch_strobe(latch_strobe),
        .register_select(register_select),
        .chain_data_output(chain_data_output),
        .open_lamp_detect(open_lamp_detect),
        .overheat_flag(overheat_flag),
        .error_flag_n_out(error_flag_n_out),
        .error_flag_n_oe(error_flag_n_oe),
        .channel_on(channel_on),
        .brightness_trim(brightness_trim),
        .irq(irq)
    );
    msl_ctrl_model ctrl (
        .shift_clock(shift_clock),
        .serial_data_input(serial_data_input),
        .latch_strobe(latch_strobe),
        .register_select(register_select)
    );
    initial forever #50 pclk = ~pclk;
    // next random word
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // trim word of channel n as a read returns it
    function automatic logic [31:0] tword(input logic [111:0] v, input int n);
        return {25'h0, v[7*n+:7]};
    endfunction
    // random 112-bit pattern
    task automatic r112(output logic [111:0] v);
        repeat (4)
        begin
            rng = xs(rng);
            v = {v[79:0], rng};
        end
    endtask
    // compare and count
    task automatic chk(input string what, input logic [111:0] e, input logic [111:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one apb transfer, result in rd and rerr
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++)
            @(posedge pclk);
        if (i == 20)
        begin
            mismatches++;
            close_out();
        end
        rd = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic settle();
        repeat (8) @(posedge pclk);
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, MSL_OFS_MASK, 32'h0);
        chk("mask reset", 32'h0, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 1'b1, rerr);
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");
        apb(1'b1, MSL_OFS_MASK, 32'h1);
        rng = xs(rng);
        onoff_v = rng[15:0] | 16'h8001;
        ctrl.send(1'b0, {96'h0, onoff_v}, 16, 1'b1);
        settle();
        chk("channel_on", onoff_v, channel_on);
        chk("irq onoff", 1'b1, irq);
        // on/off word is read-only: a write leaves it alone
        apb(1'b1, MSL_OFS_ONOFF, 32'h0);
        apb(1'b0, MSL_OFS_ONOFF, 32'h0);
        chk("onoff read", {16'h0, onoff_v}, rd);
        apb(1'b1, MSL_OFS_STATUS, 32'h1);
        $display("test onoff done");
        r112(trim_v);
        ctrl.send(1'b1, trim_v, 112, 1'b1);
        settle();
        chk("trim", trim_v, brightness_trim);
        chk("onoff kept", onoff_v, channel_on);
        chk("irq masked", 1'b0, irq);
        for (int n = 0; n < 16; n++)
        begin
            apb(1'b0, MSL_OFS_TRIM_BASE + 12'(4 * n), 32'h0);
            chk("trim word", tword(trim_v, n), rd);
        end
        // only the trim-latched event is pending now
        apb(1'b0, MSL_OFS_STATUS, 32'h0);
        chk("status trim", 32'h2, rd);
        // select high, strobe low, no error
        apb(1'b0, MSL_OFS_PINS, 32'h0);
        chk("pins", 32'h1, rd);
        apb(1'b1, MSL_OFS_STATUS, 32'h7);
        $display("test trim done");
        r112(trim_w);
        // top bit opposite to the on/off tail so the select switch shows
        trim_w[111] = ~onoff_v[15];
        ctrl.send(1'b1, trim_w, 112, 1'b0);
        settle();
        chk("trim held", trim_v, brightness_trim);
        chk("trim chain", trim_w[111], chain_data_output);
        ctrl.send(1'b0, 112'h0, 0, 1'b0);
        settle();
        chk("onoff chain", onoff_v[15], chain_data_output);
        $display("test select done");
        apb(1'b1, MSL_OFS_MASK, 32'h4);
        for (int k = 0; k < 2; k++)
        begin
            rng = xs(rng);
            if (k == 0)
                open_lamp_detect <= 16'h1 << rng[3:0];
            else
                overheat_flag <= 1'b1;
            settle();
            chk("error low", 1'b0, error_n);
            chk("irq error", 1'b1, irq);
            {open_lamp_detect, overheat_flag} <= 17'h0;
            settle();
            chk("error high", 1'b1, error_n);
            apb(1'b1, MSL_OFS_STATUS, 32'h4);
            apb(1'b0, MSL_OFS_STATUS, 32'h0);
            chk("status clear", 32'h0, rd);
            chk("irq clear", 1'b0, irq);
        end
        $display("test error done");
        close_out();
    end
endmodule
